/* design/erdw_pkg.sv */
package erdw_pkg;

   // register map of the walker, byte addresses on the AXI4-Lite port
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BASE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_MASK = 8'h0C;
   localparam logic [7:0] REG_CUR = 8'h10;
   localparam logic [7:0] REG_FRAMES = 8'h14;

   localparam int CTRL_RUN_BIT = 0;
   localparam int STAT_W = 3;
   localparam int STAT_RXDONE_BIT = 0;
   localparam int STAT_DESC_BIT = 1;
   localparam int STAT_SKIP_BIT = 2;
   localparam int W0_LAST_BIT = 8;

   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
   localparam logic [STAT_W-1:0] STATUS_RST = 3'h0;

   // offsets of the descriptor words from the descriptor start
   localparam logic [31:0] W1_OFS = 32'h0000_0004;
   localparam logic [31:0] W2_OFS = 32'h0000_0008;
   localparam logic [31:0] W3_OFS = 32'h0000_000C;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam logic [12:0] WORD_BYTES_13 = 13'h0004;
   localparam logic [1:0] FETCH_LAST_IDX = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // control word 1 of a receive descriptor
   typedef struct packed {
      logic no_irq;
      logic [14:0] rsv_hi;
      logic ring_end;
      logic chain;
      logic rsv_13;
      logic [12:0] buf1_size;
   } erdw_w1_t;

   // register write request handed from the bus slave
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } erdw_wreq_t;

endpackage : erdw_pkg

/* design/erdw_axil_slave.sv */
`timescale 1ns/1ps
module erdw_axil_slave
   import erdw_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output erdw_wreq_t wreq,
   output logic wr_go,
   input wire logic wr_err,
   output logic rd_go,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
   logic awready_ff, wready_ff, arready_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic aw_take, w_take, nxt_aw_have, nxt_w_have;

   assign aw_take = awvalid && awready_ff;
   assign w_take = wvalid && wready_ff;
   // address and data may arrive in either order; write fires once both are held
   assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
   assign nxt_aw_have = aw_take ? 1'b1 : (wr_go ? 1'b0 : aw_have_ff);
   assign nxt_w_have = w_take ? 1'b1 : (wr_go ? 1'b0 : w_have_ff);
   assign wreq = '{addr: awaddr_ff, data: wdata_ff, strb: wstrb_ff};
   assign rd_go = arvalid && arready_ff;
   assign rd_addr = araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         awready_ff <= !nxt_aw_have;
         wready_ff <= !nxt_w_have;
         if (aw_take) begin
            awaddr_ff <= awaddr;
         end
         if (w_take) begin
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (rd_go) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_data;
         rresp_ff <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_ff && rready) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

endmodule : erdw_axil_slave

/* design/erdw_walker.sv */
`timescale 1ns/1ps
module erdw_walker
   import erdw_pkg::*;
#(
   parameter logic [31:0] DESC_STRIDE = 32'h0000_0020
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic mrd_req,
   output logic [31:0] mrd_addr,
   input wire logic mrd_ack,
   input wire logic [31:0] mrd_data,
   output logic mwr_valid,
   output logic [31:0] mwr_addr,
   output logic [31:0] mwr_data,
   input wire logic mwr_ready,
   input wire logic rx_valid,
   input wire logic [31:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready,
   output logic irq
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_FETCH = 6'b000010,
      S_DECIDE = 6'b000100,
      S_XFER = 6'b001000,
      S_WBACK = 6'b010000,
      S_NEXT = 6'b100000
   } erdw_state_t;

   erdw_state_t state_ff;
   erdw_w1_t w1_ff;
   erdw_wreq_t wreq;
   logic [31:0] w2_ff, w3_ff, ctrl_ff, base_ff, cur_ff, buf_addr_ff, frames_ff;
   logic [31:0] mrd_addr_ff, mwr_addr_ff, mwr_data_ff, rd_data;
   logic [12:0] rem_ff;
   logic [1:0] idx_ff;
   logic [STAT_W-1:0] status_ff, mask_ff, nxt_status, set_vec;
   logic mrd_req_ff, mwr_valid_ff, rx_ready_ff, irq_ff, done_ff, last_ff;
   logic wr_go, rd_go, wr_err, rd_err, rx_take, mwr_take, rd_status, irq_set_ev;
   logic [7:0] rd_addr;

   // merges byte lanes of a register write
   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction : apply_strb

   // where the walk goes after a descriptor; only bits 15 and 14 are looked at
   function automatic logic [31:0] next_desc(input erdw_w1_t w1, input logic [31:0] cur,
                                             input logic [31:0] base, input logic [31:0] w3);
      logic [31:0] res;
      res = cur + DESC_STRIDE;
      if (w1.ring_end) begin
         res = base;
      end else if (w1.chain) begin
         res = w3;
      end
      return res;
   endfunction : next_desc

   erdw_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wreq(wreq),
      .wr_go(wr_go),
      .wr_err(wr_err),
      .rd_go(rd_go),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   assign rx_take = rx_valid && rx_ready_ff;
   assign mwr_take = mwr_valid_ff && mwr_ready;
   assign rd_status = rd_go && (rd_addr == REG_STATUS);
   // writes to read-only or unmapped words answer with an error
   assign wr_err = !(wreq.addr == REG_CTRL || wreq.addr == REG_BASE || wreq.addr == REG_MASK);

   always_comb begin
      rd_err = 1'b0;
      case (rd_addr)
         REG_CTRL: rd_data = ctrl_ff;
         REG_BASE: rd_data = base_ff;
         REG_STATUS: rd_data = {29'h0000_0000, status_ff};
         REG_MASK: rd_data = {29'h0000_0000, mask_ff};
         REG_CUR: rd_data = cur_ff;
         REG_FRAMES: rd_data = frames_ff;
         default: begin
            rd_data = 32'h0000_0000;
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= CTRL_RST;
         base_ff <= BASE_RST;
         mask_ff <= MASK_RST;
      end else if (wr_go) begin
         if (wreq.addr == REG_CTRL) begin
            ctrl_ff <= apply_strb(ctrl_ff, wreq.data, wreq.strb);
         end
         if (wreq.addr == REG_BASE) begin
            base_ff <= apply_strb(base_ff, wreq.data, wreq.strb);
         end
         if (wreq.addr == REG_MASK) begin
            mask_ff <= STAT_W'(apply_strb({29'h0000_0000, mask_ff}, wreq.data, wreq.strb));
         end
      end
   end

   // walker state machine and datapath
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= S_IDLE;
         cur_ff <= BASE_RST;
         w1_ff <= '0;
         w2_ff <= 32'h0000_0000;
         w3_ff <= 32'h0000_0000;
         idx_ff <= 2'h0;
         buf_addr_ff <= 32'h0000_0000;
         rem_ff <= 13'h0000;
         done_ff <= 1'b0;
         last_ff <= 1'b0;
         frames_ff <= 32'h0000_0000;
      end else begin
         case (state_ff)
            S_IDLE: begin
               // while idle, the walk restarts from the base whenever software rewrites it
               if (wr_go && wreq.addr == REG_BASE) begin
                  cur_ff <= apply_strb(base_ff, wreq.data, wreq.strb);
               end else if (ctrl_ff[CTRL_RUN_BIT]) begin
                  state_ff <= S_FETCH;
                  idx_ff <= 2'h1;
               end
            end
            S_FETCH: begin
               if (mrd_ack) begin
                  case (idx_ff)
                     2'h1: w1_ff <= erdw_w1_t'(mrd_data);
                     2'h2: w2_ff <= mrd_data;
                     default: w3_ff <= mrd_data;
                  endcase
                  idx_ff <= idx_ff + 2'h1;
                  if (idx_ff == FETCH_LAST_IDX) begin
                     state_ff <= S_DECIDE;
                  end
               end
            end
            S_DECIDE: begin
               done_ff <= 1'b0;
               last_ff <= 1'b0;
               // skip empty buffer
               // buffer 2 is never used, so an empty buffer 1 moves straight on
               if (w1_ff.buf1_size == 13'h0000) begin
                  state_ff <= S_NEXT;
               end else begin
                  buf_addr_ff <= w2_ff;
                  rem_ff <= w1_ff.buf1_size;
                  state_ff <= S_XFER;
               end
            end
            S_XFER: begin
               if (rx_take) begin
                  buf_addr_ff <= buf_addr_ff + WORD_BYTES;
                  rem_ff <= rem_ff - WORD_BYTES_13;
                  // size assumed whole words
                  // an odd size is rounded up: a whole word is still taken while under one word remains
                  if (rx_last || rem_ff <= WORD_BYTES_13) begin
                     done_ff <= 1'b1;
                     last_ff <= rx_last;
                  end
               end
               if (done_ff && !mwr_valid_ff) begin
                  state_ff <= S_WBACK;
               end
            end
            S_WBACK: begin
               if (mwr_take) begin
                  if (last_ff) begin
                     frames_ff <= frames_ff + 32'h0000_0001;
                  end
                  state_ff <= S_NEXT;
               end
            end
            S_NEXT: begin
               cur_ff <= next_desc(w1_ff, cur_ff, base_ff, w3_ff);
               idx_ff <= 2'h1;
               state_ff <= ctrl_ff[CTRL_RUN_BIT] ? S_FETCH : S_IDLE;
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // descriptor read port: request stays up across the three word reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mrd_req_ff <= 1'b0;
         mrd_addr_ff <= 32'h0000_0000;
      end else if (state_ff == S_IDLE && ctrl_ff[CTRL_RUN_BIT] && !wr_go) begin
         mrd_req_ff <= 1'b1;
         mrd_addr_ff <= cur_ff + W1_OFS;
      end else if (state_ff == S_NEXT && ctrl_ff[CTRL_RUN_BIT]) begin
         mrd_req_ff <= 1'b1;
         mrd_addr_ff <= next_desc(w1_ff, cur_ff, base_ff, w3_ff) + W1_OFS;
      end else if (state_ff == S_FETCH && mrd_ack) begin
         mrd_req_ff <= (idx_ff != FETCH_LAST_IDX);
         mrd_addr_ff <= mrd_addr_ff + WORD_BYTES;
      end
   end

   // buffer and write-back port; one word in flight keeps the stream honest
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mwr_valid_ff <= 1'b0;
         mwr_addr_ff <= 32'h0000_0000;
         mwr_data_ff <= 32'h0000_0000;
         rx_ready_ff <= 1'b0;
      end else begin
         if (rx_take) begin
            rx_ready_ff <= 1'b0;
         end else begin
            rx_ready_ff <= (state_ff == S_XFER) && !done_ff && !mwr_valid_ff;
         end
         if (rx_take) begin
            mwr_valid_ff <= 1'b1;
            mwr_addr_ff <= buf_addr_ff;
            mwr_data_ff <= rx_data;
         end else if (state_ff == S_XFER && done_ff && !mwr_valid_ff) begin
            mwr_valid_ff <= 1'b1;
            mwr_addr_ff <= cur_ff;
            mwr_data_ff <= 32'(last_ff) << W0_LAST_BIT;
         end else if (mwr_take) begin
            mwr_valid_ff <= 1'b0;
         end
      end
   end

   assign irq_set_ev = (state_ff == S_WBACK) && mwr_take && last_ff && !w1_ff.no_irq;

   always_comb begin
      set_vec = '0;
      set_vec[STAT_RXDONE_BIT] = irq_set_ev;
      set_vec[STAT_DESC_BIT] = (state_ff == S_WBACK) && mwr_take;
      set_vec[STAT_SKIP_BIT] = (state_ff == S_DECIDE) && (w1_ff.buf1_size == 13'h0000);
      // a read clears, but an event in the same cycle survives it
      nxt_status = (rd_status ? STATUS_RST : status_ff) | set_vec;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= STATUS_RST;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff <= |(status_ff & mask_ff);
      end
   end

   assign mrd_req = mrd_req_ff;
   assign mrd_addr = mrd_addr_ff;
   assign mwr_valid = mwr_valid_ff;
   assign mwr_addr = mwr_addr_ff;
   assign mwr_data = mwr_data_ff;
   assign rx_ready = rx_ready_ff;
   assign irq = irq_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_NO_IRQ_FLAG: assert property (
      (state_ff == S_WBACK && mwr_take && w1_ff.no_irq && !rd_status)
      |=> status_ff[STAT_RXDONE_BIT] == $past(status_ff[STAT_RXDONE_BIT]))
      else $error("suppressed frame set the receive-done flag");
   AST_IRQ_FLAG_SET: assert property (
      (state_ff == S_WBACK && mwr_take && last_ff && !w1_ff.no_irq)
      |=> status_ff[STAT_RXDONE_BIT])
      else $error("frame end did not set the receive-done flag");
   AST_RING_WRAP: assert property (
      (state_ff == S_NEXT && w1_ff.ring_end) |=> cur_ff == $past(base_ff))
      else $error("ring end did not return to the list base");
   AST_CHAIN_NEXT: assert property (
      (state_ff == S_NEXT && w1_ff.chain && !w1_ff.ring_end) |=> cur_ff == $past(w3_ff))
      else $error("chained descriptor not followed");
   AST_RING_OVER_CHAIN: assert property (
      (state_ff == S_NEXT && w1_ff.chain && w1_ff.ring_end && base_ff != w3_ff)
      |=> cur_ff != $past(w3_ff))
      else $error("chain pointer taken over ring end");
   AST_SKIP_EMPTY: assert property (
      (state_ff == S_DECIDE && w1_ff.buf1_size == 13'h0000)
      |=> state_ff == S_NEXT ##1 !rx_ready_ff)
      else $error("empty buffer was not skipped");
   AST_BUF1_ADDR: assert property (
      (state_ff == S_DECIDE && w1_ff.buf1_size != 13'h0000)
      |=> buf_addr_ff == $past(w2_ff) && state_ff == S_XFER)
      else $error("buffer 1 address not taken from word 2");
   AST_NEXT_FETCH: assert property (
      (state_ff == S_NEXT && ctrl_ff[CTRL_RUN_BIT])
      |=> mrd_req_ff && mrd_addr_ff == cur_ff + W1_OFS)
      else $error("next fetch not aimed at the new descriptor");
   AST_LAST_MARK: assert property (
      (state_ff == S_WBACK && mwr_valid_ff)
      |-> mwr_addr_ff == cur_ff && mwr_data_ff[W0_LAST_BIT] == last_ff)
      else $error("write-back last-descriptor bit wrong");
   AST_RESERVED_IGNORED: assert property (
      (state_ff == S_NEXT && !w1_ff.chain && !w1_ff.ring_end)
      |=> cur_ff == $past(cur_ff) + DESC_STRIDE)
      else $error("reserved bits changed the walk");
   AST_IRQ_LEVEL: assert property (
      ##1 irq_ff == $past(|(status_ff & mask_ff)))
      else $error("interrupt level does not follow masked status");

   COV_FRAME_DONE: cover property (irq_set_ev);
   COV_RING_WRAP: cover property (state_ff == S_NEXT && w1_ff.ring_end);
   COV_CHAIN: cover property (state_ff == S_NEXT && w1_ff.chain && !w1_ff.ring_end);
   COV_SPLIT_FRAME: cover property (state_ff == S_WBACK && mwr_take && !last_ff);

endmodule : erdw_walker

/* tb/erdw_mem_model.sv */
`timescale 1ns/1ps
module erdw_mem_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic mrd_req,
   input wire logic [31:0] mrd_addr,
   output logic mrd_ack,
   output logic [31:0] mrd_data,
   input wire logic mwr_valid,
   input wire logic [31:0] mwr_addr,
   input wire logic [31:0] mwr_data,
   output logic mwr_ready
);
   logic [31:0] mem [0:255];
   logic go;
   // never two acks in a row: the address only moves after an ack
   always @(posedge aclk) begin
      if (!aresetn) begin
         mrd_ack <= 1'b0;
         mrd_data <= 32'h0;
         mwr_ready <= 1'b0;
      end else begin
         go = mrd_req && !mrd_ack && ($urandom % 3 != 0);
         mrd_ack <= go;
         // data outside an ack is scrambled, not held
         mrd_data <= go ? mem[mrd_addr[9:2]] : ~mrd_data;
         mwr_ready <= ($urandom % 2) == 1;
         if (mwr_valid && mwr_ready) begin
            mem[mwr_addr[9:2]] <= mwr_data;
         end
      end
   end
endmodule : erdw_mem_model

/* tb/test_eth_rx_descriptor_walker.sv */
`timescale 1ns/1ps
module test_eth_rx_descriptor_walker;
   import erdw_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, mrd_req, mrd_ack, mwr_valid, mwr_ready;
   logic rx_valid, rx_last, rx_ready, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, mrd_addr, mrd_data, mwr_addr, mwr_data, rx_data;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] eq[$];
   logic [31:0] fq[$];
   logic [31:0] wd[0:4];
   logic [31:0] fexp[0:5];

   erdw_walker erdw_walker_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .mrd_req(mrd_req), .mrd_addr(mrd_addr), .mrd_ack(mrd_ack),
      .mrd_data(mrd_data), .mwr_valid(mwr_valid), .mwr_addr(mwr_addr), .mwr_data(mwr_data),
      .mwr_ready(mwr_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_ready(rx_ready), .irq(irq));
   erdw_mem_model erdw_mem_model_inst (.aclk(aclk), .aresetn(aresetn), .mrd_req(mrd_req),
      .mrd_addr(mrd_addr), .mrd_ack(mrd_ack), .mrd_data(mrd_data), .mwr_valid(mwr_valid),
      .mwr_addr(mwr_addr), .mwr_data(mwr_data), .mwr_ready(mwr_ready));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32

   task chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1

   task tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bvalid && n < 400) begin
         @(posedge aclk);
         n++;
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end
      chk32({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rvalid && n < 400) begin
         @(posedge aclk);
         n++;
         if (arready && arvalid) arvalid <= 1'b0;
      end
      chk32(rdata, ed);
      chk32({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   // valid stays up between words of one frame
   task send_frame(input int s, input int nw);
      int n;
      for (int i = 0; i < nw; i++) begin
         rx_valid <= 1'b1;
         rx_data <= wd[s+i];
         rx_last <= (i == nw - 1);
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (!rx_ready && n < 400);
      end
      rx_valid <= 1'b0;
      @(posedge aclk);
   endtask : send_frame

   task wait_fetch(input int k);
      int n;
      n = 0;
      while ((fq.size() < k || eq.size() != 0) && n < 2000) begin
         @(posedge aclk);
         n++;
      end
   endtask : wait_fetch

   always @(posedge aclk) begin
      if (mrd_req && mrd_ack && mrd_addr[3:0] == 4'h4) fq.push_back(mrd_addr - W1_OFS);
      if (mwr_valid && mwr_ready) begin
         if (eq.size() < 2) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, mwr_addr, 32'h0);
         end else begin
            chk32(mwr_addr, eq.pop_front());
            chk32(mwr_data, eq.pop_front());
         end
      end
   end

   initial begin
      #(4000 * 50);
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      tally_and_finish();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_valid, rx_last} = 8'h00;
      {awaddr, araddr, wstrb} = 20'h0;
      {wdata, rx_data} = 64'h0;
      void'($urandom(32'hFD42ADA3));
      // sizes kept at multiples of four
      erdw_mem_model_inst.mem[1] = 32'h7FFF_6008;
      erdw_mem_model_inst.mem[2] = 32'h0000_0200;
      erdw_mem_model_inst.mem[3] = 32'h0000_0040;
      erdw_mem_model_inst.mem[17] = 32'h0000_0000;
      erdw_mem_model_inst.mem[18] = 32'h0000_0380;
      erdw_mem_model_inst.mem[19] = 32'h0000_00C0;
      erdw_mem_model_inst.mem[25] = 32'h8000_C010;
      erdw_mem_model_inst.mem[26] = 32'h0000_0300;
      erdw_mem_model_inst.mem[27] = 32'h0000_00A0;
      fexp = '{32'h0, 32'h40, 32'h60, 32'h0, 32'h40, 32'h60};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(REG_CTRL, CTRL_RST, RESP_OKAY);
      axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
      axi_rd(REG_MASK, 32'h0, RESP_OKAY);
      axi_rd(8'h20, 32'h0, RESP_SLVERR);
      axi_wr(8'h20, 32'h1, RESP_SLVERR);
      axi_wr(REG_STATUS, 32'h7, RESP_SLVERR);
      $display("test registers done");
      for (int i = 0; i < 5; i++) wd[i] = $urandom;
      eq = '{32'h200, wd[0], 32'h204, wd[1], 32'h0, 32'h0, 32'h300, wd[2], 32'h60, 32'h100};
      axi_wr(REG_BASE, 32'h0, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
      send_frame(0, 3);
      wait_fetch(4);
      axi_rd(REG_STATUS, 32'h6, RESP_OKAY);
      chk1(irq, 1'b0);
      $display("test frame across three descriptors done");
      axi_wr(REG_MASK, 32'h1, RESP_OKAY);
      eq = '{32'h200, wd[3], 32'h204, wd[4], 32'h0, 32'h100};
      send_frame(3, 2);
      wait_fetch(6);
      chk1(irq, 1'b1);
      axi_rd(REG_STATUS, 32'h7, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk1(irq, 1'b0);
      axi_rd(REG_FRAMES, 32'h2, RESP_OKAY);
      // fetch order through chain, skip and ring end
      for (int i = 0; i < 6; i++) chk32(fq[i], fexp[i]);
      $display("test ring wrap frame done");
      tally_and_finish();
   end
endmodule : test_eth_rx_descriptor_walker
